// File: design/ebu_pkg.sv
// Package with constants and carrier types of the external bus unit
package ebu_pkg;
  // Bus modes
  localparam logic [2:0] MODE_SINGLE = 3'h0;
  localparam logic [2:0] MODE_DEMUX16 = 3'h1;
  localparam logic [2:0] MODE_MUX16 = 3'h2;
  localparam logic [2:0] MODE_MUX8 = 3'h3;
  localparam logic [2:0] MODE_DEMUX8 = 3'h4;
  // Address space size codes
  localparam logic [1:0] ASP_64K = 2'h0;
  localparam logic [1:0] ASP_256K = 2'h1;
  localparam logic [1:0] ASP_1M = 2'h2;
  localparam logic [1:0] ASP_4M = 2'h3;
  // Segment line counts per size code
  localparam int SEG_LINES_64K = 0;
  localparam int SEG_LINES_256K = 2;
  localparam int SEG_LINES_1M = 4;
  localparam int SEG_LINES_4M = 6;
  localparam int SEG_LINES_CAN = 4;
  // System configuration bit positions
  localparam int SYSCFG_EXT_PERIPH_ENABLE_BIT_BIT = 2;
  localparam int SYSCFG_UNLATCHED_SELECT_BIT_BIT = 6;
  // Window count
  localparam int NUM_WINDOWS = 4;
  localparam int NUM_CS = 4;
  // Extension RAM window: 2 KByte
  localparam logic [21:0] EXTENSION_RAM_BASE = 22'h00_E000;
  localparam logic [21:0] EXTENSION_RAM_MASK = 22'h3F_F800;
  // Reset values
  localparam logic [15:0] SYSCFG_RST = 16'h0000;

  // Bus characteristics of one region
  typedef struct packed {
    logic [2:0] mode;
    logic [3:0] mctc;
    logic mttc;
    logic alectl;
    logic rwdly;
    logic cs_en;
  } ebu_cfg_t;

  // Window select: base and size mask
  typedef struct packed {
    logic [21:0] base;
    logic [21:0] mask;
    logic en;
  } ebu_win_t;

  // Request from the CPU
  typedef struct packed {
    logic valid;
    logic wr;
    logic word;
    logic [21:0] addr;
    logic [15:0] wdata;
  } ebu_req_t;
endpackage : ebu_pkg

// File: design/ebu_top.sv
// External bus unit: mode select, windows, chip selects and bus sequencing
module ebu_top #(
  parameter int AW = 22
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Configuration
  input wire logic [15:0] i_system_config_reg,
  input wire logic [1:0] i_addr_space,
  input wire logic i_can_on_seg_port,
  input wire ebu_pkg::ebu_cfg_t i_default_bus_config_reg,
  input wire ebu_pkg::ebu_cfg_t [3:0] i_window_bus_config_reg,
  input wire ebu_pkg::ebu_win_t [3:0] i_window_select_reg,
  // CPU side
  input wire ebu_pkg::ebu_req_t i_req,
  output logic o_ready,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic o_extension_ram_sel,
  // External pins
  input wire logic [15:0] i_muxed_data_port,
  output logic [15:0] o_muxed_data_port,
  output logic [15:0] o_muxed_data_oe_n,
  output logic [15:0] o_address_port,
  output logic [5:0] o_seg_addr,
  output logic [5:0] o_seg_oe_n,
  output logic o_ale,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [3:0] o_cs_n
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_ADDR = 6'b00_0010,
    ST_DLY = 6'b00_0100,
    ST_DATA = 6'b00_1000,
    ST_TRI = 6'b01_0000,
    ST_EXTENSION_RAM = 6'b10_0000
  } ebu_state_t;

  typedef struct packed {
    ebu_state_t st;
    logic [3:0] cnt;
    ebu_pkg::ebu_cfg_t cfg;
    logic [3:0] cs_lat;
    logic wr;
    logic word;
    logic [AW-1:0] addr;
    logic [15:0] wdata;
    logic [15:0] din_s1;
    logic [15:0] din_s2;
    logic ready;
    logic done;
    logic [15:0] rdata;
    logic xsel;
    logic [15:0] dout;
    logic [15:0] doe_n;
    logic [15:0] aport;
    logic [5:0] seg;
    logic [5:0] seg_oe_n;
    logic ale;
    logic rd_n;
    logic wr_n;
    logic [3:0] cs_n;
  } ebu_regs_t;

  ebu_regs_t s_r;
  ebu_regs_t s_nxt;

  // Window hit test
  function automatic logic win_hit(input ebu_pkg::ebu_win_t w, input logic [AW-1:0] a);
    win_hit = w.en && ((a & w.mask[AW-1:0]) == (w.base[AW-1:0] & w.mask[AW-1:0]));
  endfunction : win_hit

  // Number of segment lines for a size code
  function automatic int seg_lines(input logic [1:0] sp, input logic can);
    int n;
    n = ebu_pkg::SEG_LINES_4M;
    case (sp)
      ebu_pkg::ASP_64K: n = ebu_pkg::SEG_LINES_64K;
      ebu_pkg::ASP_256K: n = ebu_pkg::SEG_LINES_256K;
      ebu_pkg::ASP_1M: n = ebu_pkg::SEG_LINES_1M;
      default: n = ebu_pkg::SEG_LINES_4M;
    endcase
    if (can && n > ebu_pkg::SEG_LINES_CAN) begin
      n = ebu_pkg::SEG_LINES_CAN;
    end
    seg_lines = n;
  endfunction : seg_lines

  logic ext_periph_enable_bit;
  logic unlatched_select_bit;
  logic [3:0] hit;
  logic is_extension_ram;
  ebu_pkg::ebu_cfg_t sel_cfg;
  logic [3:0] sel_cs;
  logic [5:0] seg_mask;
  int nseg;

  assign ext_periph_enable_bit = i_system_config_reg[ebu_pkg::SYSCFG_EXT_PERIPH_ENABLE_BIT_BIT];
  assign unlatched_select_bit = i_system_config_reg[ebu_pkg::SYSCFG_UNLATCHED_SELECT_BIT_BIT];

  // Region decode with window priority
  always_comb begin
    for (int i = 0; i < ebu_pkg::NUM_WINDOWS; i++) begin
      hit[i] = win_hit(i_window_select_reg[i], i_req.addr[AW-1:0]);
    end
    is_extension_ram = ext_periph_enable_bit && ((i_req.addr & ebu_pkg::EXTENSION_RAM_MASK) == ebu_pkg::EXTENSION_RAM_BASE);
    sel_cfg = i_default_bus_config_reg;
    sel_cs = 4'b0001;
    if (hit[3]) begin
      sel_cfg = i_window_bus_config_reg[3];
      sel_cs = 4'b0000;
    end else if (hit[2]) begin
      sel_cfg = i_window_bus_config_reg[2];
      sel_cs = 4'b1000;
    end else if (hit[1]) begin
      sel_cfg = i_window_bus_config_reg[1];
      sel_cs = 4'b0100;
    end else if (hit[0]) begin
      sel_cfg = i_window_bus_config_reg[0];
      sel_cs = 4'b0010;
    end
    if (!sel_cfg.cs_en) begin
      sel_cs = 4'b0000;
    end
    nseg = seg_lines(i_addr_space, i_can_on_seg_port);
    for (int i = 0; i < 6; i++) begin
      seg_mask[i] = (i < nseg);
    end
  end

  logic ext_mode;
  logic mux_mode;
  logic bus8;
  assign ext_mode = (s_r.cfg.mode != ebu_pkg::MODE_SINGLE);
  assign mux_mode = (s_r.cfg.mode == ebu_pkg::MODE_MUX16) ||
                    (s_r.cfg.mode == ebu_pkg::MODE_MUX8);
  assign bus8 = (s_r.cfg.mode == ebu_pkg::MODE_MUX8) ||
                (s_r.cfg.mode == ebu_pkg::MODE_DEMUX8);

  always_comb begin
    s_nxt = s_r;
    s_nxt.din_s1 = i_muxed_data_port;
    s_nxt.din_s2 = s_r.din_s1;
    s_nxt.done = 1'b0;
    s_nxt.seg_oe_n = ~seg_mask;
    case (s_r.st)
      ST_IDLE: begin
        s_nxt.ready = 1'b1;
        s_nxt.cs_n = 4'hF;
        s_nxt.doe_n = 16'hFFFF;
        if (i_req.valid && s_r.ready) begin
          s_nxt.ready = 1'b0;
          s_nxt.wr = i_req.wr;
          s_nxt.word = i_req.word;
          s_nxt.addr = i_req.addr[AW-1:0];
          s_nxt.wdata = i_req.wdata;
          s_nxt.cfg = sel_cfg;
          s_nxt.cs_lat = sel_cs;
          s_nxt.xsel = is_extension_ram;
          if (is_extension_ram) begin
            s_nxt.st = ST_EXTENSION_RAM;
          end else if (sel_cfg.mode == ebu_pkg::MODE_SINGLE) begin
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.st = ST_ADDR;
            s_nxt.cnt = sel_cfg.alectl ? 4'h1 : 4'h0;
            s_nxt.aport = i_req.addr[15:0];
            s_nxt.seg = i_req.addr[21:16] & seg_mask;
            s_nxt.ale = 1'b1;
            s_nxt.cs_n = unlatched_select_bit ? ~sel_cs : 4'hF;
            if (sel_cfg.mode == ebu_pkg::MODE_MUX16 || sel_cfg.mode == ebu_pkg::MODE_MUX8) begin
              s_nxt.dout = i_req.addr[15:0];
              s_nxt.doe_n = 16'h0000;
            end
          end
        end
      end
      ST_ADDR: begin
        s_nxt.cs_n = ~s_r.cs_lat;
        if (s_r.cnt == 4'h0) begin
          s_nxt.ale = 1'b0;
          s_nxt.doe_n = 16'hFFFF;
          s_nxt.st = ST_DLY;
          s_nxt.cnt = s_r.cfg.rwdly ? 4'h0 : 4'h1;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      ST_DLY: begin
        if (s_r.cnt == 4'h0) begin
          s_nxt.st = ST_DATA;
          s_nxt.cnt = s_r.cfg.mctc;
          s_nxt.rd_n = s_r.wr;
          s_nxt.wr_n = ~s_r.wr;
          if (s_r.wr) begin
            s_nxt.dout = s_r.wdata;
            s_nxt.doe_n = bus8 ? 16'hFF00 : 16'h0000;
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      ST_DATA: begin
        if (s_r.cnt == 4'h0) begin
          s_nxt.rd_n = 1'b1;
          s_nxt.wr_n = 1'b1;
          s_nxt.rdata = bus8 ? {8'h00, s_r.din_s2[7:0]} : s_r.din_s2;
          s_nxt.done = 1'b1;
          s_nxt.st = ST_TRI;
          s_nxt.cnt = s_r.cfg.mttc ? 4'h0 : 4'h1;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      ST_TRI: begin
        s_nxt.doe_n = 16'hFFFF;
        s_nxt.cs_n = 4'hF;
        if (s_r.cnt == 4'h0) begin
          s_nxt.st = ST_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      ST_EXTENSION_RAM: begin
        s_nxt.done = 1'b1;
        s_nxt.xsel = 1'b0;
        s_nxt.st = ST_IDLE;
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    if (!ext_mode && s_r.st != ST_IDLE && s_r.st != ST_EXTENSION_RAM) begin
      s_nxt.st = ST_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.doe_n <= 16'hFFFF;
      s_r.seg_oe_n <= 6'h3F;
      s_r.rd_n <= 1'b1;
      s_r.wr_n <= 1'b1;
      s_r.cs_n <= 4'hF;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_ready = s_r.ready;
  assign o_done = s_r.done;
  assign o_rdata = s_r.rdata;
  assign o_extension_ram_sel = s_r.xsel;
  assign o_muxed_data_port = s_r.dout;
  assign o_muxed_data_oe_n = s_r.doe_n;
  assign o_address_port = s_r.aport;
  assign o_seg_addr = s_r.seg;
  assign o_seg_oe_n = s_r.seg_oe_n;
  assign o_ale = s_r.ale;
  assign o_rd_n = s_r.rd_n;
  assign o_wr_n = s_r.wr_n;
  assign o_cs_n = s_r.cs_n;

  // Checks
  AST_ALE_FIRST: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    $rose(s_r.ale) |-> (s_r.rd_n && s_r.wr_n)) else $error("strobe overlaps data");
  AST_CS_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (s_r.st == ST_IDLE && $past(s_r.st) == ST_IDLE) |-> (s_r.cs_n == 4'hF)) else $error("cs idle");
  AST_SEG_64K: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_addr_space == ebu_pkg::ASP_64K) |=> (s_r.seg_oe_n == 6'h3F)) else $error("seg 64k");
  AST_SEG_CAN: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_can_on_seg_port |=> (s_r.seg_oe_n[5:4] == 2'b11)) else $error("can seg");
  AST_SEG_FULL: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_addr_space == ebu_pkg::ASP_4M && !i_can_on_seg_port) |=> (s_r.seg_oe_n == 6'h00))
    else $error("seg full");
  AST_EXTENSION_RAM_FAST: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (s_r.st == ST_EXTENSION_RAM) |=> (s_r.done && s_r.st == ST_IDLE)) else $error("extension_ram slow");
  AST_RDWR_EXCL: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !(!s_r.rd_n && !s_r.wr_n)) else $error("rd and wr");
  AST_CS_ONEHOT: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    $onehot0(~s_r.cs_n)) else $error("cs multi");
  AST_DONE_LEAVE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (s_r.st == ST_DATA && s_r.cnt == 4'h0) |=> (s_r.done ##1 1'b1)) else $error("done");
  COV_MUX: cover property (@(posedge i_sys_clk) s_r.ale && s_r.doe_n == 16'h0000);
  COV_WR: cover property (@(posedge i_sys_clk) !s_r.wr_n);
  COV_EXTENSION_RAM: cover property (@(posedge i_sys_clk) s_r.st == ST_EXTENSION_RAM);
endmodule : ebu_top

// File: verif/ebu_mem_model.sv
// Behavioural external memory on the far side of the bus unit
module ebu_mem_model (
  // Clock and mode
  input wire logic i_sys_clk,
  input wire logic i_mux,
  input wire logic i_bus8,
  // Bus pins
  input wire logic [15:0] i_port,
  input wire logic [15:0] i_addr,
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  output logic [15:0] o_port
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:511];
  logic [15:0] lat_r = 16'h0000;
  logic [15:0] junk_r = 16'h0000;
  logic [8:0] idx;
  logic [8:0] ix;
  // Address from the latched port or the dedicated address port
  assign idx = i_mux ? lat_r[8:0] : i_addr[8:0];
  assign ix = i_bus8 ? idx : {idx[8:1], 1'h0};
  always @(posedge i_sys_clk) begin
    junk_r <= ~junk_r;
    if (i_ale) begin
      lat_r <= i_port;
    end
    if (!i_wr_n) begin
      mem[ix] <= i_port[7:0];
      if (!i_bus8) begin
        mem[ix | 9'h001] <= i_port[15:8];
      end
    end
  end
  // Released lines show a toggling pattern, upper byte too in 8-bit modes
  assign o_port = i_rd_n ? junk_r :
    {i_bus8 ? junk_r[15:8] : mem[ix | 9'h001], mem[ix]};
endmodule : ebu_mem_model

// File: verif/ebu_top_tb.sv
// Self-checking testbench of the external bus unit
module ebu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] md;
    logic u;
    logic [21:0] a;
    logic w;
    logic wd;
    logic [15:0] d;
    logic [15:0] er;
    logic [3:0] ecs;
  } ebu_row_t;
  logic i_sys_clk;
  logic i_reset_n;
  logic [15:0] sys;
  logic [1:0] asp;
  logic can;
  ebu_pkg::ebu_cfg_t cfg;
  ebu_pkg::ebu_win_t [3:0] win;
  ebu_pkg::ebu_req_t req;
  logic o_ready;
  logic o_done;
  logic [15:0] o_rdata;
  logic o_extension_ram_sel;
  logic [15:0] din;
  logic [15:0] dout;
  logic [15:0] doe;
  logic [15:0] adr;
  logic [5:0] sga;
  logic [5:0] sgoe;
  logic ale;
  logic rd_n;
  logic wr_n;
  logic [3:0] cs_n;
  logic [3:0] scs;
  logic sst;
  logic sx;
  logic [5:0] soe;
  logic [5:0] sg;
  logic [5:0] eo;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  ebu_row_t rows [9];

  ebu_top uut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_system_config_reg(sys),
    .i_addr_space(asp), .i_can_on_seg_port(can), .i_default_bus_config_reg(cfg),
    .i_window_bus_config_reg({4{cfg}}), .i_window_select_reg(win), .i_req(req),
    .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata), .o_extension_ram_sel(o_extension_ram_sel),
    .i_muxed_data_port(din), .o_muxed_data_port(dout), .o_muxed_data_oe_n(doe),
    .o_address_port(adr), .o_seg_addr(sga), .o_seg_oe_n(sgoe), .o_ale(ale),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_cs_n(cs_n));
  ebu_mem_model mem (.i_sys_clk(i_sys_clk),
    .i_mux(cfg.mode == ebu_pkg::MODE_MUX16 || cfg.mode == ebu_pkg::MODE_MUX8),
    .i_bus8(cfg.mode == ebu_pkg::MODE_MUX8 || cfg.mode == ebu_pkg::MODE_DEMUX8),
    .i_port(dout), .i_addr(adr), .i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n), .o_port(din));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // One CPU access; pin activity is gathered until the done pulse
  task automatic acc(input logic [21:0] a, input logic w, input logic wd, input logic [15:0] d);
    int k;
    scs = 4'hF;
    sst = 1'h1;
    sx = 1'h0;
    soe = 6'h3F;
    sg = 6'h00;
    while (o_ready !== 1'h1) @(negedge i_sys_clk);
    @(posedge i_sys_clk);
    req <= '{1'h1, w, wd, a, d};
    @(posedge i_sys_clk);
    req.valid <= 1'h0;
    for (k = 0; k < 200; k++) begin
      @(negedge i_sys_clk);
      scs = scs & cs_n;
      sst = sst & rd_n & wr_n;
      sx = sx | o_extension_ram_sel;
      soe = soe & sgoe;
      if (!(rd_n & wr_n)) sg = sga;
      if (o_done === 1'h1) break;
    end
    if (k == 200) chk("done", 16'h0001, 16'h0000);
  endtask : acc

  initial begin
    i_sys_clk = 1'h0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    i_reset_n = 1'h0;
    sys = 16'h0000;
    asp = ebu_pkg::ASP_4M;
    can = 1'h0;
    cfg = '{ebu_pkg::MODE_DEMUX16, 4'h2, 1'h0, 1'h0, 1'h0, 1'h1};
    req = '0;
    win[0] = '{22'h10_0000, 22'h3F_0000, 1'h1};
    win[1] = '{22'h10_0000, 22'h3F_0000, 1'h1};
    win[2] = '{22'h20_0000, 22'h3F_0000, 1'h1};
    win[3] = '{22'h20_0000, 22'h3F_8000, 1'h1};
    rows = '{
      '{ebu_pkg::MODE_DEMUX16, 1'h0, 22'h30_0010, 1'h1, 1'h1, 16'hA5C3, 16'h0000, 4'hE},
      '{ebu_pkg::MODE_DEMUX16, 1'h0, 22'h30_0010, 1'h0, 1'h1, 16'h0000, 16'hA5C3, 4'hE},
      '{ebu_pkg::MODE_MUX16, 1'h0, 22'h10_0020, 1'h1, 1'h1, 16'h1234, 16'h0000, 4'hB},
      '{ebu_pkg::MODE_MUX16, 1'h0, 22'h10_0020, 1'h0, 1'h1, 16'h0000, 16'h1234, 4'hB},
      '{ebu_pkg::MODE_MUX8, 1'h0, 22'h20_8031, 1'h1, 1'h0, 16'h005A, 16'h0000, 4'h7},
      '{ebu_pkg::MODE_MUX8, 1'h0, 22'h20_8031, 1'h0, 1'h0, 16'h0000, 16'h005A, 4'h7},
      '{ebu_pkg::MODE_DEMUX8, 1'h0, 22'h20_0040, 1'h1, 1'h0, 16'h0077, 16'h0000, 4'hF},
      '{ebu_pkg::MODE_DEMUX8, 1'h0, 22'h20_0040, 1'h0, 1'h0, 16'h0000, 16'h0077, 4'hF},
      '{ebu_pkg::MODE_DEMUX16, 1'h1, 22'h30_0010, 1'h0, 1'h1, 16'h0000, 16'hA5C3, 4'hE}};
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk("cs_rst", 16'h000F, 16'(cs_n));
    chk("oe_rst", 16'hFFFF, doe);
    @(posedge i_sys_clk);
    i_reset_n <= 1'h1;
    for (int i = 0; i < 9; i++) begin
      @(posedge i_sys_clk);
      cfg.mode <= rows[i].md;
      cfg.mctc <= 4'(i % 3 + 2);
      cfg.alectl <= i[0];
      cfg.rwdly <= i[1];
      sys <= {9'h000, rows[i].u, 6'h00};
      acc(rows[i].a, rows[i].w, rows[i].wd, rows[i].d);
      chk("cs", 16'(rows[i].ecs), 16'(scs));
      if (!rows[i].w) chk("rdata", rows[i].er, o_rdata);
    end
    @(posedge i_sys_clk);
    cfg.mode <= ebu_pkg::MODE_SINGLE;
    acc(22'h30_0010, 1'h0, 1'h1, 16'h0000);
    chk("single", 16'h001F, {11'h000, sst, scs});
    @(posedge i_sys_clk);
    cfg.mode <= ebu_pkg::MODE_DEMUX16;
    sys <= 16'h0004;
    acc(22'h00_E010, 1'h1, 1'h1, 16'hBEEF);
    acc(22'h00_E010, 1'h0, 1'h1, 16'h0000);
    chk("extension_ram_rd", 16'hA5C3, o_rdata);
    chk("extension_ram_pins", 16'h003F, {10'h000, sst, sx, scs});
    @(posedge i_sys_clk);
    sys <= 16'h0000;
    acc(22'h00_E010, 1'h0, 1'h1, 16'h0000);
    chk("xoff_rd", 16'hA5C3, o_rdata);
    chk("xoff_pins", 16'h000E, {10'h000, sst, sx, scs});
    for (int s = 0; s < 5; s++) begin
      @(posedge i_sys_clk);
      asp <= 2'(s < 4 ? s : 3);
      can <= (s == 4);
      acc(22'h2A_0010, 1'h0, 1'h1, 16'h0000);
      eo = (s == 4) ? 6'h30 : ~6'((1 << (2 * s)) - 1);
      chk("seg_oe", 16'(eo), 16'(soe));
      chk("seg", 16'(6'h2A & ~eo), 16'(sg & ~eo));
    end
    report_and_stop();
  end
endmodule : ebu_top_tb
